// ===== hdl/rst_seq_pkg.sv
// Package: timing constants and states for the flash reset sequencer
package rst_seq_pkg;
  localparam int unsigned CLK_MHZ              = 25;
  localparam int unsigned POWER_UP_DELAY_US    = 300;
  localparam int unsigned RESET_HOLD_INTERVAL_US = 35;
  localparam int unsigned RESET_SETUP_HIGH_NS  = 50;
  localparam int unsigned RESET_PULSE_WIDTH_NS = 200;
  localparam int unsigned RESET_RELEASE_HOLD_NS = 50;
  localparam int unsigned CLK_PERIOD_NS        = 1000 / CLK_MHZ;
  // Longest time rounds down
  localparam int unsigned POWER_UP_CYC   = POWER_UP_DELAY_US * CLK_MHZ;
  // Least times round up
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_INTERVAL_US * CLK_MHZ;
  localparam int unsigned SETUP_HIGH_CYC =
    (RESET_SETUP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_WIDTH_CYC =
    (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_HOLD_CYC =
    (RESET_RELEASE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 14;

  typedef enum logic [2:0] {
    ST_POR     = 3'b000,
    ST_STANDBY = 3'b001,
    ST_ACTIVE  = 3'b011,
    ST_BUSY    = 3'b010,
    ST_HWRST   = 3'b110,
    ST_RSTHOLD = 3'b111
  } dev_state_e;

  typedef enum logic [2:0] {
    HS_WAIT_PU  = 3'b100,
    HS_IDLE     = 3'b001,
    HS_PULSE    = 3'b011,
    HS_RELEASE  = 3'b111,
    HS_SETUP    = 3'b101
  } host_state_e;
endpackage : rst_seq_pkg

// ===== hdl/rst_seq_if.sv
// Interface: chip select and reset pins between host and flash
interface rst_seq_if;
  logic cs_b;
  logic reset_b;
  logic dev_ready;
  modport device (input cs_b, input reset_b, output dev_ready);
  modport host   (output cs_b, output reset_b, input dev_ready);
endinterface : rst_seq_if

// ===== hdl/flash_rst_dev.sv
// Device end: power-on reset, hardware reset and power mode sequencing
// Behaviour
// - Chip select low means enabled, active power
// - After deselect, stay active until work done
// - Run power-on reset, refuse commands until done
// - Power-up delay is at most 300 us
// - Host keeps select high during power-up delay
// - Reset input ignored during power-on reset
// - Reset held past power-up: select waits 50 ns
// - Reset at power-up end keeps reset state
// - Reset fall restores registers within 35 us
// - Failed power-on reset makes reset rerun it fully
// - Reset stays high 50 ns before next fall
// - Reset low 200 ns aborts, tristates, goes standby (o_abort stays low when reset reruns power-on reset)
// - Host raises select during reset hold interval
// - Pulse width plus release hold covers interval
module flash_rst_dev #(
  parameter int unsigned POWER_UP_CYC   = rst_seq_pkg::POWER_UP_CYC,
  parameter int unsigned RESET_HOLD_CYC = rst_seq_pkg::RESET_HOLD_CYC
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  // Pins
  rst_seq_if.device pins,
  // Core side
  input  wire logic i_op_busy,
  input  wire logic i_por_fail,
  output logic      o_abort,
  output logic      o_cmd_enable,
  output logic      o_out_enable,
  output logic      o_active_power,
  output logic      o_reg_restore
);
  import rst_seq_pkg::*;

  // Counts must fit the shared counter; zero would wrap to a phase of the full counter range
  if (POWER_UP_CYC < 1 || POWER_UP_CYC >= (1 << CNT_W)) begin : g_bad_pu
    $error("flash_rst_dev: power-up count out of range");
  end
  if (RESET_HOLD_CYC < 1 ||
      RESET_HOLD_CYC >= (1 << CNT_W)) begin : g_bad_rh
    $error("flash_rst_dev: reset hold count out of range");
  end
  // The power-up wait may be shortened but never exceed its maximum
  if (POWER_UP_CYC > rst_seq_pkg::POWER_UP_CYC) begin : g_long_pu
    $error("flash_rst_dev: power-up count above its maximum");
  end

  localparam logic [CNT_W-1:0] PU_LAST = CNT_W'(POWER_UP_CYC - 1);
  localparam logic [CNT_W-1:0] RH_LAST = CNT_W'(RESET_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] RL_LAST = CNT_W'(RELEASE_HOLD_CYC - 1);
  localparam int unsigned      PIN_N   = 2;
  localparam int unsigned      PIN_CS  = 0;
  localparam int unsigned      PIN_RST = 1;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s;
  logic             rst_q_r;
  logic             por_bad_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  dev_state_e       state_r;
  dev_state_e       state_nxt;

  // Two flip-flops on each pin before any logic reads it
  assign pin_raw = {pins.reset_b, pins.cs_b};

  for (genvar g = 0; g < PIN_N; g++) begin : g_sync
    logic [1:0] sync_r;
    // Both pins idle high; loading high avoids a false edge after reset
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
        sync_r <= 2'h3;
      end else begin
        sync_r <= {sync_r[0], pin_raw[g]};
      end
    end
    assign pin_s[g] = sync_r[1];
  end

  wire cs_b_s   = pin_s[PIN_CS];
  wire rst_b_s  = pin_s[PIN_RST];
  wire rst_fall = rst_q_r & ~rst_b_s;
  wire pu_done  = (cnt_r == PU_LAST);
  wire rh_done  = (cnt_r == RH_LAST);
  wire rl_done  = (cnt_r == RL_LAST);
  wire st_por   = (state_r == ST_POR);
  wire st_hwrst = (state_r == ST_HWRST);
  wire st_hold  = (state_r == ST_RSTHOLD);
  wire st_work  = (state_r == ST_ACTIVE) || (state_r == ST_BUSY);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      ST_POR: begin
        // Reset pin level not looked at until the delay ends
        cnt_nxt = cnt_r + CNT_W'(1);
        if (pu_done) begin
          cnt_nxt   = '0;
          state_nxt = rst_b_s ? ST_STANDBY : ST_RSTHOLD;
        end
      end
      ST_STANDBY, ST_ACTIVE, ST_BUSY: begin
        if (rst_fall) begin
          cnt_nxt   = '0;
          state_nxt = (por_bad_r || i_por_fail) ? ST_POR : ST_HWRST;
        end else if (!cs_b_s) begin
          state_nxt = ST_ACTIVE;
        end else if (i_op_busy) begin
          state_nxt = ST_BUSY;
        end else begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_HWRST: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (rh_done) begin
          cnt_nxt   = '0;
          state_nxt = rst_b_s ? ST_STANDBY : ST_RSTHOLD;
        end
      end
      ST_RSTHOLD: begin
        // Held in reset while the pin is low; select waits the release hold
        cnt_nxt = rst_b_s ? cnt_r + CNT_W'(1) : '0;
        if (rst_b_s && rl_done) begin
          cnt_nxt   = '0;
          state_nxt = ST_STANDBY;
        end
      end
      default: begin
        state_nxt = ST_POR;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_POR;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Previous synchronised level feeds the falling-edge detector
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_q_r <= 1'b1;
    end else begin
      rst_q_r <= rst_b_s;
    end
  end

  // A failed power-on reset is kept until a full one runs; a failure
  // reported in the same cycle as the clear wins
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_bad_r <= 1'b0;
    end else if (i_por_fail) begin
      por_bad_r <= 1'b1;
    end else if (st_por) begin
      por_bad_r <= 1'b0;
    end
  end

  wire in_reset = st_por | st_hwrst | st_hold;
  wire up       = ~in_reset;

  assign o_cmd_enable   = up & ~cs_b_s;
  assign o_out_enable   = up & ~cs_b_s;
  assign o_abort        = st_hwrst | st_hold;
  assign o_reg_restore  = in_reset;
  assign o_active_power = st_work;
  assign pins.dev_ready = up;
endmodule : flash_rst_dev

// ===== hdl/flash_rst_host.sv
// Host end: drives chip select and reset pin with required spacings
module flash_rst_host #(
  parameter int unsigned POWER_UP_CYC   = rst_seq_pkg::POWER_UP_CYC,
  parameter int unsigned RESET_HOLD_CYC = rst_seq_pkg::RESET_HOLD_CYC
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  // Pins
  rst_seq_if.host   pins,
  // User side
  input  wire logic i_select_req,
  input  wire logic i_reset_req,
  output logic      o_ready,
  output logic      o_reset_busy
);
  import rst_seq_pkg::*;

  // Pulse never below its minimum; pulse plus release covers the hold
  localparam int unsigned PW =
    (PULSE_WIDTH_CYC + RELEASE_HOLD_CYC > RESET_HOLD_CYC) ?
    PULSE_WIDTH_CYC : RESET_HOLD_CYC - RELEASE_HOLD_CYC;

  if (POWER_UP_CYC < 1 || POWER_UP_CYC >= (1 << CNT_W)) begin : g_bad_pu
    $error("flash_rst_host: power-up count out of range");
  end
  if (RESET_HOLD_CYC <= RELEASE_HOLD_CYC ||
      RESET_HOLD_CYC >= (1 << CNT_W)) begin : g_bad_rh
    $error("flash_rst_host: reset hold count out of range");
  end

  host_state_e      state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             cs_b_r, rst_b_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + CNT_W'(1);
    unique case (state_r)
      HS_WAIT_PU:
        if (cnt_r == CNT_W'(POWER_UP_CYC - 1)) begin
          state_nxt = HS_SETUP;
          cnt_nxt   = '0;
        end
      HS_IDLE:
        if (i_reset_req) begin
          state_nxt = HS_PULSE;
          cnt_nxt   = '0;
        end
      // Pulse plus release hold together cover the hold interval
      HS_PULSE:
        if (cnt_r == CNT_W'(PW - 1)) begin
          state_nxt = HS_RELEASE;
          cnt_nxt   = '0;
        end
      HS_RELEASE:
        if (cnt_r == CNT_W'(RELEASE_HOLD_CYC - 1)) begin
          state_nxt = HS_SETUP;
          cnt_nxt   = '0;
        end
      HS_SETUP: begin
        // Count saturates so a slow device cannot wrap it
        if (cnt_r >= CNT_W'(SETUP_HIGH_CYC))
          cnt_nxt = cnt_r;
        if (cnt_r >= CNT_W'(SETUP_HIGH_CYC - 1) && pins.dev_ready)
          state_nxt = HS_IDLE;
      end
      default: begin
        state_nxt = HS_WAIT_PU;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= HS_WAIT_PU;
      cnt_r   <= '0;
      cs_b_r  <= 1'b1;
      rst_b_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cs_b_r  <= ~(state_nxt == HS_IDLE && i_select_req);
      rst_b_r <= (state_nxt != HS_PULSE);
    end
  end

  assign pins.cs_b    = cs_b_r;
  assign pins.reset_b = rst_b_r;
  assign o_ready      = (state_r == HS_IDLE);
  assign o_reset_busy = (state_r == HS_PULSE) || (state_r == HS_RELEASE);
endmodule : flash_rst_host

// ===== tb/rst_seq_props.sv
// Checker: timing relations on the chip select and reset pins
module rst_seq_props #(
  parameter int unsigned POWER_UP_CYC   = 20,
  parameter int unsigned RESET_HOLD_CYC = 10
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Pins
  input wire logic cs_b,
  input wire logic reset_b,
  input wire logic dev_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned por_cnt_r;
  int unsigned fall_cnt_r;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // Counts saturate so long runs never wrap into a false window
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      por_cnt_r  <= 0;
      fall_cnt_r <= RESET_HOLD_CYC;
    end else begin
      if (por_cnt_r < POWER_UP_CYC + 8) por_cnt_r <= por_cnt_r + 1;
      if ($fell(reset_b)) fall_cnt_r <= 0;
      else if (fall_cnt_r < RESET_HOLD_CYC) fall_cnt_r <= fall_cnt_r + 1;
    end
  end
  por_quiet_a: assert property (
    por_cnt_r < POWER_UP_CYC - 1 |-> !dev_ready)
    else $error("ready before power-up delay");
  por_done_a: assert property (
    por_cnt_r == POWER_UP_CYC + 4 |-> dev_ready)
    else $error("ready late after power-up");
  setup_high_a: assert property ($fell(reset_b) |-> $past(reset_b, 2))
    else $error("reset pin high too briefly");
  pulse_width_a: assert property ($fell(reset_b) |-> !reset_b [*5])
    else $error("reset pulse too short");
  ready_drop_a: assert property ($fell(reset_b) |-> ##[1:5] !dev_ready)
    else $error("reset fall not seen");
  hold_span_a: assert property (
    fall_cnt_r > 5 && fall_cnt_r < RESET_HOLD_CYC |-> !dev_ready)
    else $error("ready inside reset hold");
  cs_in_reset_a: assert property (!reset_b |-> cs_b)
    else $error("select low during reset");
  release_hold_a: assert property ($rose(reset_b) |-> cs_b [*3])
    else $error("select low too soon");
  ready_select_a: assert property (!dev_ready |-> cs_b)
    else $error("select while not ready");
endmodule : rst_seq_props

// ===== tb/tb_serial_flash_reset_sequencer.sv
// Testbench: host and flash ends joined across the pin interface
module tb_serial_flash_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_seq_pkg::*;
  localparam int unsigned PU_CYC   = 40;
  localparam int unsigned HOLD_CYC = 10;
  logic i_clk_sys, i_rst_b, i_op_busy, i_por_fail, i_select_req;
  logic i_reset_req, o_abort, o_cmd_enable, o_out_enable, o_active_power;
  logic o_reg_restore, o_ready, o_reset_busy;
  int   err_count = 0;
  int   tests_run = 0;
  int   n;
  rst_seq_if rst_seq_if_inst ();
  flash_rst_dev #(.POWER_UP_CYC(PU_CYC), .RESET_HOLD_CYC(HOLD_CYC))
    flash_rst_dev_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .pins(rst_seq_if_inst), .i_op_busy(i_op_busy), .i_por_fail(i_por_fail),
    .o_abort(o_abort), .o_cmd_enable(o_cmd_enable),
    .o_out_enable(o_out_enable), .o_active_power(o_active_power),
    .o_reg_restore(o_reg_restore));
  flash_rst_host #(.POWER_UP_CYC(PU_CYC), .RESET_HOLD_CYC(HOLD_CYC))
    flash_rst_host_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .pins(rst_seq_if_inst), .i_select_req(i_select_req),
    .i_reset_req(i_reset_req), .o_ready(o_ready),
    .o_reset_busy(o_reset_busy));
  rst_seq_props #(.POWER_UP_CYC(PU_CYC), .RESET_HOLD_CYC(HOLD_CYC))
    rst_seq_props_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .cs_b(rst_seq_if_inst.cs_b), .reset_b(rst_seq_if_inst.reset_b),
    .dev_ready(rst_seq_if_inst.dev_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge i_clk_sys);
    #1;
  endtask : step
  task automatic wait_ready(output int k);
    k = 0;
    while (o_ready !== 1'b1 && k < 500) begin
      step(1);
      k++;
    end
    check(k < 500, 1'b1);
  endtask : wait_ready
  // Cycle count covers the request edge and the mid-reset look
  task automatic hw_reset(input logic fail, output int k);
    i_por_fail = fail;
    step(2);
    i_por_fail  = 1'b0;
    i_reset_req = 1'b1;
    step(1);
    i_reset_req = 1'b0;
    i_op_busy   = 1'b0;
    step(5);
    check({rst_seq_if_inst.cs_b, rst_seq_if_inst.reset_b, o_reset_busy,
      o_reg_restore, o_cmd_enable, o_out_enable}, 6'h2c);
    if (!fail) check(o_abort, 1'b1);
    wait_ready(k);
    k = k + 6;
  endtask : hw_reset
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #(40 * 3000);
    err_count++;
    report_and_stop();
  end
  initial begin
    i_rst_b      = 1'b0;
    i_op_busy    = 1'b0;
    i_por_fail   = 1'b0;
    i_select_req = 1'b0;
    i_reset_req  = 1'b1;
    step(12);
    i_rst_b = 1'b1;
    step(10);
    check({rst_seq_if_inst.dev_ready, rst_seq_if_inst.cs_b,
      rst_seq_if_inst.reset_b, o_cmd_enable}, 4'h6);
    i_reset_req = 1'b0;
    wait_ready(n);
    check(n + 10 >= PU_CYC, 1'b1);
    check({rst_seq_if_inst.dev_ready, o_active_power}, 2'h2);
    i_select_req = 1'b1;
    step(4);
    check({rst_seq_if_inst.cs_b, o_active_power, o_cmd_enable,
      o_out_enable}, 4'h7);
    i_op_busy    = 1'b1;
    i_select_req = 1'b0;
    step(4);
    check({rst_seq_if_inst.cs_b, o_active_power, o_cmd_enable}, 3'h6);
    i_op_busy = 1'b0;
    step(3);
    check(o_active_power, 1'b0);
    i_select_req = 1'b1;
    i_op_busy    = 1'b1;
    step(4);
    hw_reset(1'b0, n);
    check(n >= HOLD_CYC && n < PU_CYC, 1'b1);
    step(4);
    check({rst_seq_if_inst.cs_b, o_abort}, 2'h0);
    i_select_req = 1'b0;
    hw_reset(1'b1, n);
    check(n >= PU_CYC, 1'b1);
    hw_reset(1'b0, n);
    check(n < PU_CYC, 1'b1);
    i_rst_b = 1'b0;
    step(2);
    check(rst_seq_if_inst.dev_ready, 1'b0);
    i_rst_b = 1'b1;
    wait_ready(n);
    check(n >= PU_CYC, 1'b1);
    report_and_stop();
  end
endmodule : tb_serial_flash_reset_sequencer
